// *** src/clec_pkg.sv ***
// What this block does
// - PWM side raises one reload pulse per configured reload rate of PWM periods.
// - Each reload pulse restarts the trigger unit time base.
// - Enabled trigger unit forwards reload at once to both converters and gate driver.
// - Reload makes the trigger unit fetch first times and converters fetch commands.
// - First trigger after reload is refused for up to 10 bus cycles.
// - Later triggers need 6 or 10 cycles load; closer spacing flags timing error.
// - Converter fetches first command within 10 cycles, no conversion meanwhile.
// - Time base equal to stored time pulses that generator's trigger.
// - Trigger 0 goes only to converter 0, trigger 1 only to converter 1.
// - Equal times in both generators give triggers in one cycle.
// - Converter trigger starts the next sequence with the already fetched command.
// - Commutation event becomes an asynchronous reload.
// - Asynchronous reload updates lists and reinitialises list pointers.
// - Enabled trigger unit forwards asynchronous reload at once as sequence abort.
// - Global load confirm reaches PWM, trigger unit and both converters together.
// - Only the programmable reload output and its async qualifier leave the PWM side.
// - Async qualifier follows a commutation reload, not when coinciding with normal one.
// - Commutation edge code: 00 level, 01 rising, 10 falling, 11 both.
package clec_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned TIME_W = 16;
  localparam int unsigned LIST_DEPTH = 4;
  localparam int unsigned PTR_W = 2;
  localparam int unsigned PERIOD_W = 15;
  localparam int unsigned RATE_W = 4;
  localparam int unsigned CMD_W = 3;
  localparam int unsigned LOAD_W = 4;
  // Figures are given in bus cycles, so the bus clock rate is one cycle per unit
  localparam int unsigned FIRST_LOAD_BUS_CYC = 10;
  localparam int unsigned LOAD_ONE_GEN_BUS_CYC = 6;
  localparam int unsigned LOAD_TWO_GEN_BUS_CYC = 10;
  localparam int unsigned ADC_FETCH_BUS_CYC = 10;
  localparam logic [LOAD_W-1:0] FIRST_LOAD_CYC = LOAD_W'(FIRST_LOAD_BUS_CYC * 1);
  localparam logic [LOAD_W-1:0] LOAD_ONE_GEN_CYC = LOAD_W'(LOAD_ONE_GEN_BUS_CYC * 1);
  localparam logic [LOAD_W-1:0] LOAD_TWO_GEN_CYC = LOAD_W'(LOAD_TWO_GEN_BUS_CYC * 1);
  localparam logic [LOAD_W-1:0] ADC_FETCH_CYC = LOAD_W'(ADC_FETCH_BUS_CYC * 1);
  localparam logic [1:0] EDGE_LEVEL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [PERIOD_W-1:0] PERIOD_RST = 15'h0000;
  localparam logic [RATE_W-1:0] RATE_RST = 4'h0;
  localparam logic [TIME_W-1:0] TIME_RST = 16'h0000;
  localparam logic [CMD_W-1:0] CMD_RST = 3'h0;
  typedef enum logic [1:0] {CLEC_IDLE, CLEC_FETCH, CLEC_ARMED} clec_adc_e;
endpackage : clec_pkg

// *** src/clec_pwm_reload.sv ***
`timescale 1ns/1ps
module clec_pwm_reload import clec_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic [PERIOD_W-1:0] period,
  input wire logic [RATE_W-1:0] rate_m1,
  input wire logic [1:0] edge_sel,
  input wire logic restart_en,
  input wire logic commutation_event,
  output logic reload,
  output logic reload_async_qualifier
);
  logic [PERIOD_W-1:0] pwm_cnt;
  logic [RATE_W-1:0] rate_cnt;
  logic comm_prev;
  logic comm_hit;
  logic normal_hit;

  always_comb begin
    unique case (edge_sel)
      EDGE_LEVEL: comm_hit = commutation_event;
      EDGE_RISE: comm_hit = commutation_event & ~comm_prev;
      EDGE_FALL: comm_hit = ~commutation_event & comm_prev;
      EDGE_BOTH: comm_hit = commutation_event ^ comm_prev;
    endcase
  end

  assign normal_hit = enable && pwm_cnt == period && rate_cnt == rate_m1;

  always_ff @(posedge clk) begin
    if (rst) begin
      comm_prev <= 1'b0;
    end else begin
      comm_prev <= commutation_event;
    end
  end

  // Commutation restart realigns the PWM period to the new sector
  always_ff @(posedge clk) begin
    if (rst || !enable || (comm_hit && restart_en)) begin
      pwm_cnt <= PERIOD_RST;
      rate_cnt <= RATE_RST;
    end else if (pwm_cnt == period) begin
      pwm_cnt <= PERIOD_RST;
      rate_cnt <= (rate_cnt == rate_m1) ? RATE_RST : rate_cnt + 4'h1;
    end else begin
      pwm_cnt <= pwm_cnt + 15'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reload <= 1'b0;
      reload_async_qualifier <= 1'b0;
    end else begin
      reload <= normal_hit || (enable && restart_en && comm_hit);
      // Coinciding normal reload stays a plain reload
      reload_async_qualifier <= enable && restart_en && comm_hit && !normal_hit;
    end
  end
endmodule : clec_pwm_reload

// *** src/clec_adc_seq.sv ***
`timescale 1ns/1ps
module clec_adc_seq import clec_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic restart,
  input wire logic seq_abort,
  input wire logic trigger,
  input wire logic load_confirm_in,
  output logic conv_start,
  output logic [CMD_W-1:0] cmd_idx,
  output logic trig_lost,
  output logic list_sel,
  output logic aborted
);
  clec_adc_e state;
  logic [LOAD_W-1:0] fetch_cnt;
  logic swap_pending;

  always_ff @(posedge clk) begin
    if (rst || seq_abort) begin
      state <= CLEC_IDLE;
      fetch_cnt <= '0;
      cmd_idx <= CMD_RST;
    end else if (restart) begin
      state <= CLEC_FETCH;
      fetch_cnt <= ADC_FETCH_CYC;
      cmd_idx <= CMD_RST;
    end else begin
      unique case (state)
        CLEC_IDLE: state <= CLEC_IDLE;
        CLEC_FETCH: begin
          // Conversion held off until the command is in place
          fetch_cnt <= fetch_cnt - 4'h1;
          if (fetch_cnt == 4'h1) begin
            state <= CLEC_ARMED;
          end
        end
        CLEC_ARMED: begin
          if (trigger) begin
            state <= CLEC_FETCH;
            fetch_cnt <= ADC_FETCH_CYC;
            cmd_idx <= cmd_idx + 3'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      conv_start <= 1'b0;
      trig_lost <= 1'b0;
      aborted <= 1'b0;
    end else begin
      conv_start <= trigger && state == CLEC_ARMED && !restart && !seq_abort;
      trig_lost <= trigger && !(state == CLEC_ARMED && !restart && !seq_abort);
      aborted <= seq_abort;
    end
  end

  // A confirmed load switches the command list at the next restart
  always_ff @(posedge clk) begin
    if (rst) begin
      swap_pending <= 1'b0;
      list_sel <= 1'b0;
    end else if (restart && (swap_pending || load_confirm_in)) begin
      swap_pending <= 1'b0;
      list_sel <= ~list_sel;
    end else if (load_confirm_in) begin
      swap_pending <= 1'b1;
    end
  end
endmodule : clec_adc_seq

// *** src/clec_event_chain.sv ***
`timescale 1ns/1ps
module clec_event_chain import clec_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic pwm_enable,
  input wire logic [PERIOD_W-1:0] pwm_period,
  input wire logic [RATE_W-1:0] pwm_rate_m1,
  input wire logic [1:0] comm_edge_sel,
  input wire logic comm_restart_en,
  input wire logic compare_channel_zero,
  input wire logic trigger_unit_en,
  input wire logic [1:0] gen_en,
  input wire logic list_wr,
  input wire logic list_gen,
  input wire logic [PTR_W-1:0] list_idx,
  input wire logic [TIME_W-1:0] list_time,
  input wire logic [PTR_W:0] list_len0,
  input wire logic [PTR_W:0] list_len1,
  input wire logic load_confirm_in,
  input wire logic timing_err_clr,
  output logic pwm_reload,
  output logic reload_async_qualifier,
  output logic gate_driver_reload,
  output logic adc0_restart,
  output logic adc1_restart,
  output logic adc0_seq_abort,
  output logic adc1_seq_abort,
  output logic trigger_0,
  output logic trigger_1,
  output logic adc0_conv_start,
  output logic adc1_conv_start,
  output logic [CMD_W-1:0] adc0_cmd_idx,
  output logic [CMD_W-1:0] adc1_cmd_idx,
  output logic adc0_trig_lost,
  output logic adc1_trig_lost,
  output logic adc0_list_sel,
  output logic adc1_list_sel,
  output logic adc0_aborted,
  output logic adc1_aborted,
  output logic pwm_load_confirm,
  output logic trigger_unit_load_confirm,
  output logic [TIME_W-1:0] time_base,
  output logic [1:0] timing_err,
  output logic [1:0] list_bank
);
  logic [TIME_W-1:0] shadow_time [2][LIST_DEPTH];
  logic [TIME_W-1:0] act_time [2][LIST_DEPTH];
  logic [PTR_W:0] act_len [2];
  logic [PTR_W:0] shadow_len [2];
  logic [PTR_W:0] ptr [2];
  logic [LOAD_W-1:0] load_cnt [2];
  logic [1:0] gen_done;
  logic list_update_pending;
  logic load_confirm_q;
  logic any_reload;
  logic [1:0] hit;
  logic [1:0] fire;
  logic [LOAD_W-1:0] spacing;

  function automatic logic time_match(input logic [TIME_W-1:0] tb, input logic [TIME_W-1:0] t);
    time_match = tb == t;
  endfunction : time_match

  // Only the programmable reload and its async qualifier leave the PWM side
  clec_pwm_reload u_pwm (
    .clk(clk),
    .rst(rst),
    .enable(pwm_enable),
    .period(pwm_period),
    .rate_m1(pwm_rate_m1),
    .edge_sel(comm_edge_sel),
    .restart_en(comm_restart_en),
    .commutation_event(compare_channel_zero),
    .reload(pwm_reload),
    .reload_async_qualifier(reload_async_qualifier)
  );

  assign any_reload = pwm_reload;
  // Load counted from the cycle after a fire, so spacing of exactly 6 or 10 is allowed
  assign spacing = ((gen_en == 2'h3) ? LOAD_TWO_GEN_CYC : LOAD_ONE_GEN_CYC) - 4'h1;

  always_comb begin
    for (int g = 0; g < 2; g++) begin
      hit[g] = trigger_unit_en && gen_en[g] && !gen_done[g] && !any_reload
        && time_match(time_base, act_time[g][ptr[g][PTR_W-1:0]]);
      fire[g] = hit[g] && load_cnt[g] == '0;
    end
  end

  // One register stage keeps every output on a flop; all receivers see it together
  always_ff @(posedge clk) begin
    if (rst) begin
      load_confirm_q <= 1'b0;
      pwm_load_confirm <= 1'b0;
      trigger_unit_load_confirm <= 1'b0;
    end else begin
      load_confirm_q <= load_confirm_in;
      pwm_load_confirm <= load_confirm_in;
      trigger_unit_load_confirm <= load_confirm_in;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      gate_driver_reload <= 1'b0;
      adc0_restart <= 1'b0;
      adc1_restart <= 1'b0;
      adc0_seq_abort <= 1'b0;
      adc1_seq_abort <= 1'b0;
    end else begin
      gate_driver_reload <= trigger_unit_en && pwm_reload;
      adc0_restart <= trigger_unit_en && pwm_reload;
      adc1_restart <= trigger_unit_en && pwm_reload;
      adc0_seq_abort <= trigger_unit_en && reload_async_qualifier;
      adc1_seq_abort <= trigger_unit_en && reload_async_qualifier;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      time_base <= TIME_RST;
    end else if (any_reload) begin
      time_base <= TIME_RST;
    end else if (time_base != {TIME_W{1'b1}}) begin
      time_base <= time_base + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int g = 0; g < 2; g++) begin
        for (int i = 0; i < LIST_DEPTH; i++) begin
          shadow_time[g][i] <= TIME_RST;
        end
      end
    end else if (list_wr) begin
      shadow_time[list_gen][list_idx] <= list_time;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      list_update_pending <= 1'b0;
    end else if (load_confirm_q) begin
      list_update_pending <= 1'b1;
    end else if (any_reload) begin
      list_update_pending <= 1'b0;
    end
  end

  // New lists only take effect at a reload so a running cycle is never torn
  always_ff @(posedge clk) begin
    if (rst) begin
      list_bank <= 2'h0;
      for (int g = 0; g < 2; g++) begin
        act_len[g] <= '0;
        shadow_len[g] <= '0;
        for (int i = 0; i < LIST_DEPTH; i++) begin
          act_time[g][i] <= TIME_RST;
        end
      end
    end else begin
      shadow_len[0] <= list_len0;
      shadow_len[1] <= list_len1;
      if (any_reload && (list_update_pending || reload_async_qualifier)) begin
        list_bank <= list_bank + 2'h1;
        act_time <= shadow_time;
        act_len <= shadow_len;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      gen_done <= 2'h3;
      for (int g = 0; g < 2; g++) begin
        ptr[g] <= '0;
        load_cnt[g] <= '0;
      end
    end else if (any_reload) begin
      for (int g = 0; g < 2; g++) begin
        ptr[g] <= '0;
        load_cnt[g] <= FIRST_LOAD_CYC;
        gen_done[g] <= 1'b0;
      end
    end else begin
      for (int g = 0; g < 2; g++) begin
        if (fire[g]) begin
          ptr[g] <= ptr[g] + 3'h1;
          load_cnt[g] <= spacing;
          gen_done[g] <= ptr[g] + 3'h1 >= act_len[g];
        end else if (load_cnt[g] != '0) begin
          load_cnt[g] <= load_cnt[g] - 4'h1;
        end
        if (ptr[g] >= act_len[g]) begin
          gen_done[g] <= 1'b1;
        end
      end
    end
  end

  // A refused trigger sets the flag and wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      timing_err <= 2'h0;
    end else begin
      for (int g = 0; g < 2; g++) begin
        if (hit[g] && !fire[g]) begin
          timing_err[g] <= 1'b1;
        end else if (timing_err_clr) begin
          timing_err[g] <= 1'b0;
        end
      end
    end
  end

  // Same-cycle hits on both lists give simultaneous sampling
  always_ff @(posedge clk) begin
    if (rst) begin
      trigger_0 <= 1'b0;
      trigger_1 <= 1'b0;
    end else begin
      trigger_0 <= fire[0];
      trigger_1 <= fire[1];
    end
  end

  clec_adc_seq u_adc0 (
    .clk(clk),
    .rst(rst),
    .restart(adc0_restart),
    .seq_abort(adc0_seq_abort),
    .trigger(trigger_0),
    .load_confirm_in(load_confirm_q),
    .conv_start(adc0_conv_start),
    .cmd_idx(adc0_cmd_idx),
    .trig_lost(adc0_trig_lost),
    .list_sel(adc0_list_sel),
    .aborted(adc0_aborted)
  );

  clec_adc_seq u_adc1 (
    .clk(clk),
    .rst(rst),
    .restart(adc1_restart),
    .seq_abort(adc1_seq_abort),
    .trigger(trigger_1),
    .load_confirm_in(load_confirm_q),
    .conv_start(adc1_conv_start),
    .cmd_idx(adc1_cmd_idx),
    .trig_lost(adc1_trig_lost),
    .list_sel(adc1_list_sel),
    .aborted(adc1_aborted)
  );
endmodule : clec_event_chain

// *** verif/clec_event_chain_checker.sv ***
`timescale 1ns/1ps
module clec_event_chain_checker import clec_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic pwm_enable,
  input wire logic [1:0] comm_edge_sel,
  input wire logic comm_restart_en,
  input wire logic compare_channel_zero,
  input wire logic trigger_unit_en,
  input wire logic load_confirm_in,
  input wire logic pwm_reload,
  input wire logic reload_async_qualifier,
  input wire logic gate_driver_reload,
  input wire logic adc0_restart,
  input wire logic adc1_restart,
  input wire logic adc0_seq_abort,
  input wire logic adc1_seq_abort,
  input wire logic trigger_0,
  input wire logic trigger_1,
  input wire logic adc0_conv_start,
  input wire logic adc1_conv_start,
  input wire logic pwm_load_confirm,
  input wire logic trigger_unit_load_confirm,
  input wire logic [TIME_W-1:0] time_base
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_reload_fwd: assert property ({gate_driver_reload, adc0_restart, adc1_restart} ==
    {3{$past(pwm_reload) && $past(trigger_unit_en)}}) else $error("reload forward wrong");
  chk_abort_fwd: assert property ({adc0_seq_abort, adc1_seq_abort} ==
    {2{$past(reload_async_qualifier) && $past(trigger_unit_en)}}) else $error("abort wrong");
  chk_qual_pair: assert property (reload_async_qualifier |-> pwm_reload)
    else $error("qualifier without reload");
  chk_confirm_fanout: assert property ({pwm_load_confirm, trigger_unit_load_confirm} ==
    {2{$past(load_confirm_in)}}) else $error("load confirm fanout wrong");
  chk_base_restart: assert property (pwm_reload |=> time_base == 16'h0000)
    else $error("time base not restarted");
  chk_first_window: assert property (pwm_reload |=>
    (!trigger_0 && !trigger_1) [*8] ##1 (!trigger_0 && !trigger_1) [*2])
    else $error("trigger inside load window");
  chk_no_early_conv: assert property (adc0_restart |=>
    (!adc0_conv_start && !adc1_conv_start) [*8] ##1 (!adc0_conv_start && !adc1_conv_start) [*2])
    else $error("conversion inside fetch window");
  chk_trig_route: assert property ((adc0_conv_start |-> $past(trigger_0)) and
    (adc1_conv_start |-> $past(trigger_1))) else $error("conversion without own trigger");
  chk_comm_edge: assert property ((pwm_enable && comm_restart_en &&
    ((comm_edge_sel == EDGE_RISE && $rose(compare_channel_zero)) ||
    (comm_edge_sel == EDGE_FALL && $fell(compare_channel_zero)))) |=> pwm_reload)
    else $error("commutation edge gave no reload");
endmodule : clec_event_chain_checker

bind clec_event_chain clec_event_chain_checker i_chk (.clk, .rst, .pwm_enable, .comm_edge_sel,
  .comm_restart_en, .compare_channel_zero, .trigger_unit_en, .load_confirm_in, .pwm_reload,
  .reload_async_qualifier, .gate_driver_reload, .adc0_restart, .adc1_restart, .adc0_seq_abort,
  .adc1_seq_abort, .trigger_0, .trigger_1, .adc0_conv_start, .adc1_conv_start,
  .pwm_load_confirm, .trigger_unit_load_confirm, .time_base);

// *** verif/clec_comm_timer.sv ***
`timescale 1ns/1ps
module clec_comm_timer (
  input wire logic clk,
  input wire logic rst,
  input wire logic toggle_req,
  output logic compare_out
);
  // Toggle mode, so every compare flips the line and both edges count
  always_ff @(posedge clk) begin
    if (rst) begin
      compare_out <= 1'b0;
    end else if (toggle_req) begin
      compare_out <= ~compare_out;
    end
  end
endmodule : clec_comm_timer

// *** verif/clec_event_chain_tb.sv ***
`timescale 1ns/1ps
module clec_event_chain_tb import clec_pkg::*; ();
  logic clk = 1'b0, rst = 1'b1, pwm_enable = 1'b0, comm_restart_en = 1'b0, cmp_toggle = 1'b0;
  logic trigger_unit_en = 1'b1, list_wr = 1'b0, list_gen = 1'b0, load_confirm_in = 1'b0;
  logic timing_err_clr = 1'b0, compare_channel_zero;
  logic [PERIOD_W-1:0] pwm_period = 15'h0031;
  logic [RATE_W-1:0] pwm_rate_m1 = 4'h0;
  logic [1:0] comm_edge_sel = 2'h1, gen_en = 2'h0, timing_err, list_bank;
  logic [PTR_W-1:0] list_idx = 2'h0;
  logic [TIME_W-1:0] list_time = 16'h0000, time_base;
  logic [PTR_W:0] list_len0 = 3'h0, list_len1 = 3'h0;
  logic [CMD_W-1:0] adc0_cmd_idx, adc1_cmd_idx;
  logic pwm_reload, reload_async_qualifier, gate_driver_reload, adc0_restart, adc1_restart;
  logic adc0_seq_abort, adc1_seq_abort, trigger_0, trigger_1, adc0_conv_start, adc1_conv_start;
  logic adc0_trig_lost, adc1_trig_lost, adc0_list_sel, adc1_list_sel, adc0_aborted, adc1_aborted;
  logic pwm_load_confirm, trigger_unit_load_confirm;
  int failures = 0, n_tests = 0;

  clec_event_chain i_dut (.clk, .rst, .pwm_enable, .pwm_period, .pwm_rate_m1, .comm_edge_sel,
    .comm_restart_en, .compare_channel_zero, .trigger_unit_en, .gen_en, .list_wr, .list_gen,
    .list_idx, .list_time, .list_len0, .list_len1, .load_confirm_in, .timing_err_clr,
    .pwm_reload, .reload_async_qualifier, .gate_driver_reload, .adc0_restart, .adc1_restart,
    .adc0_seq_abort, .adc1_seq_abort, .trigger_0, .trigger_1, .adc0_conv_start,
    .adc1_conv_start, .adc0_cmd_idx, .adc1_cmd_idx, .adc0_trig_lost, .adc1_trig_lost,
    .adc0_list_sel, .adc1_list_sel, .adc0_aborted, .adc1_aborted, .pwm_load_confirm,
    .trigger_unit_load_confirm, .time_base, .timing_err, .list_bank);
  clec_comm_timer i_timer (.clk, .rst, .toggle_req(cmp_toggle), .compare_out(compare_channel_zero));

  always #2 clk = ~clk;

  task automatic end_sim;
    $display("comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (exp !== got) begin
      failures++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  task automatic wait_reload;
    for (int k = 0; k < 200 && pwm_reload !== 1'b1; k++) tick(1);
  endtask : wait_reload

  task automatic wr(input logic g, input logic [1:0] i, input logic [15:0] t);
    list_gen = g;
    list_idx = i;
    list_time = t;
    tick(1);
  endtask : wr

  task automatic t_rate(input logic [3:0] r);
    int n;
    pwm_rate_m1 = r;
    load_confirm_in = 1'b1;
    tick(1);
    load_confirm_in = 1'b0;
    repeat (2) begin
      wait_reload;
      tick(1);
    end
    for (n = 1; n < 300 && pwm_reload !== 1'b1; n++) tick(1);
    check("reload spacing", 32'(50 * (r + 1)), 32'(n));
    $display("test reload rate done");
  endtask : t_rate

  task automatic t_fwd(input logic en);
    trigger_unit_en = en;
    wait_reload;
    tick(1);
    check("reload forward", {29'h0, {3{en}}},
      {29'h0, gate_driver_reload, adc0_restart, adc1_restart});
    trigger_unit_en = 1'b1;
    $display("test forward done");
  endtask : t_fwd

  // Cycle counts are taken from the negedge where the reload pulse is seen
  task automatic t_trig(input logic [1:0] ge, input logic [2:0] n0, input logic [15:0] a0,
      input logic [15:0] a1, input logic [15:0] b0, input int x0, input int x1, input int xb,
      input logic [1:0] xerr);
    int f0 = 0, s0 = 0, f1 = 0, c0 = 0, c1 = 0, l0 = 0;
    logic ls;
    wait_reload;
    tick(30);
    gen_en = ge;
    list_len0 = n0;
    list_len1 = {2'h0, ge[1]};
    list_wr = 1'b1;
    wr(1'b0, 2'h0, a0);
    wr(1'b0, 2'h1, a1);
    wr(1'b1, 2'h0, b0);
    list_wr = 1'b0;
    timing_err_clr = 1'b1;
    ls = adc0_list_sel;
    load_confirm_in = 1'b1;
    tick(1);
    timing_err_clr = 1'b0;
    load_confirm_in = 1'b0;
    wait_reload;
    for (int i = 1; i < 26; i++) begin
      tick(1);
      if (trigger_0 === 1'b1 && f0 != 0 && s0 == 0) s0 = i;
      if (trigger_0 === 1'b1 && f0 == 0) f0 = i;
      if (trigger_1 === 1'b1 && f1 == 0) f1 = i;
      if (adc0_conv_start === 1'b1 && c0 == 0) c0 = i;
      if (adc1_conv_start === 1'b1 && c1 == 0) c1 = i;
      if (adc0_trig_lost === 1'b1 && l0 == 0) l0 = i;
    end
    check("adc0 lost trigger", 32'(x1 != 0 ? x1 + 1 : 0), 32'(l0));
    check("cmd index", {26'h0, 3'(xb != 0), 3'(x0 != 0)}, {26'h0, adc1_cmd_idx, adc0_cmd_idx});
    check("list select", {30'h0, ~ls, ~ls}, {30'h0, adc1_list_sel, adc0_list_sel});
    check("first trigger_0", 32'(x0), 32'(f0));
    check("second trigger_0", 32'(x1), 32'(s0));
    check("first trigger_1", 32'(xb), 32'(f1));
    check("adc0 start", 32'(x0 != 0 ? x0 + 1 : 0), 32'(c0));
    check("adc1 start", 32'(xb != 0 ? xb + 1 : 0), 32'(c1));
    check("timing error", {30'h0, xerr}, {30'h0, timing_err});
    $display("test trigger list done");
  endtask : t_trig

  task automatic t_comm;
    logic exp, sr, sq, sa, sb;
    logic [1:0] bank;
    comm_restart_en = 1'b1;
    for (int c = 0; c < 4; c++) begin
      comm_edge_sel = 2'(c);
      trigger_unit_en = (c != 2);
      repeat (2) begin
        wait_reload;
        tick(5);
        bank = list_bank;
        cmp_toggle = 1'b1;
        tick(1);
        cmp_toggle = 1'b0;
        exp = (c == 3) || (compare_channel_zero === 1'b1 ? c != 2 : c == 2);
        {sr, sq, sa, sb} = 4'h0;
        repeat (4) begin
          tick(1);
          sr |= pwm_reload;
          sq |= reload_async_qualifier;
          sa |= adc0_seq_abort & adc1_seq_abort;
          sb |= adc0_aborted & adc1_aborted;
        end
        // Level mode keeps firing while high, so its falling toggle proves nothing
        if (c != 0 || compare_channel_zero === 1'b1) begin
          check("comm reload", {31'h0, exp}, {31'h0, sr});
          check("async qualifier", {31'h0, exp}, {31'h0, sq});
          check("seq abort", {31'h0, exp & trigger_unit_en}, {31'h0, sa});
          check("abort flag", {31'h0, exp & trigger_unit_en}, {31'h0, sb});
          if (c != 0) begin
            check("list bank", {30'h0, exp ? 2'(bank + 2'h1) : bank}, {30'h0, list_bank});
          end
        end
      end
    end
    trigger_unit_en = 1'b1;
    comm_restart_en = 1'b0;
    $display("test commutation done");
  endtask : t_comm

  initial begin
    #40000;
    failures++;
    end_sim;
  end

  initial begin
    tick(2);
    rst = 1'b0;
    pwm_enable = 1'b1;
    t_rate(4'h1);
    t_rate(4'h0);
    t_fwd(1'b0);
    t_fwd(1'b1);
    t_trig(2'h3, 3'h1, 16'h000c, 16'h0000, 16'h000c, 14, 0, 14, 2'h0);
    t_trig(2'h1, 3'h2, 16'h000a, 16'h0010, 16'h0000, 12, 18, 0, 2'h0);
    t_trig(2'h1, 3'h2, 16'h000c, 16'h0011, 16'h0000, 14, 0, 0, 2'h1);
    t_trig(2'h3, 3'h2, 16'h000c, 16'h0015, 16'h000c, 14, 0, 14, 2'h1);
    t_trig(2'h1, 3'h1, 16'h0009, 16'h0000, 16'h0000, 0, 0, 0, 2'h1);
    t_comm;
    end_sim;
  end
endmodule : clec_event_chain_tb
